// ===== verilog/i2c_slave_ctrl.sv
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
// Notes on behaviour
// - Receive interrupt enable bit 9 lets a received byte raise the interrupt.
// - Stop interrupt enable bit 8 lets a bus stop raise the interrupt.
// - Force no-acknowledge bit 7 set: every byte, address included, gets no acknowledge.
// - Bit 7 clear: hardware decides acknowledge for each byte itself.
// - Stretch bit 6 set while SCL low: hold SCL low at once.
// - Stretch bit 6 set while SCL high: hold after next falling edge.
// - Clearing stretch bit releases SCL so the master may raise it.
module i2c_slave_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C clock line, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // I2C data line, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Interrupt
  output logic irq
);

  // Synchronised levels and events from the front end
  i2c_line_if line ();

  i2c_slave_pkg::core_state_t r;
  i2c_slave_pkg::core_state_t n;

  // Address decode, shared by read and write
  // Only the six register offsets 0x00 to 0x14 decode; anything else is unmapped
  function automatic i2c_slave_pkg::reg_sel_t addr_sel(input logic [7:0] a);
    case (a)
      `OFS_SLAVE_CONTROL: addr_sel = i2c_slave_pkg::SEL_CTRL;
      `OFS_IRQ_STATUS: addr_sel = i2c_slave_pkg::SEL_STATUS;
      `OFS_IRQ_MASK: addr_sel = i2c_slave_pkg::SEL_MASK;
      `OFS_LINK_STATUS: addr_sel = i2c_slave_pkg::SEL_LINK;
      `OFS_RX_DATA: addr_sel = i2c_slave_pkg::SEL_RXDATA;
      `OFS_OWN_ADDR: addr_sel = i2c_slave_pkg::SEL_OWNADDR;
      default: addr_sel = i2c_slave_pkg::SEL_NONE;
    endcase
  endfunction

  // Read value of one register
  function automatic logic [31:0] read_word(input i2c_slave_pkg::reg_sel_t s,
                                            input i2c_slave_pkg::core_state_t c,
                                            input logic scl_lv,
                                            input logic sda_lv);
    logic [31:0] w;
    // Reserved bits read as zero
    w = 32'h0000_0000;
    case (s)
      i2c_slave_pkg::SEL_CTRL: w[15:0] = c.ctrl;
      i2c_slave_pkg::SEL_STATUS: w[1:0] = c.irq_status;
      i2c_slave_pkg::SEL_MASK: w[1:0] = c.irq_mask;
      // Link levels come from the synchronisers, not the raw pins
      i2c_slave_pkg::SEL_LINK: begin
        w[`LS_SCL] = scl_lv;
        w[`LS_SDA] = sda_lv;
        w[`LS_HOLD] = c.hold;
        w[`LS_PENDING] = c.hold_pending;
        w[`LS_ADDRESSED] = c.addressed;
        w[`LS_LAST_ACK] = c.last_ack;
      end
      // Last received byte, kept until the next one
      i2c_slave_pkg::SEL_RXDATA: w[7:0] = c.rx_data;
      i2c_slave_pkg::SEL_OWNADDR: w[6:0] = c.own_addr;
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction

  // Control bit that enables one interrupt source
  function automatic logic src_enable_of(input logic [15:0] c, input int idx);
    logic e;
    e = 1'b0;
    case (idx)
      `IRQ_RX: e = c[`BIT_RX_IRQ_ENABLE];
      `IRQ_STOP: e = c[`BIT_STOP_IRQ_ENABLE];
      default: e = 1'b0;
    endcase
    src_enable_of = e;
  endfunction

  // Pin synchronisers and bus condition detection
  // Raw pins pass two flops there before any logic here reads them
  // Edges are found one stage later, from the synchronised levels
  i2c_line_front u_front (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line.front)
  );

  // Helpers of the next-state process
  logic wr_access;
  logic [1:0] ev_set;
  wire [1:0] src_enable;
  logic stretch_rise;
  logic ack_now;
  i2c_slave_pkg::reg_sel_t wr_sel;
  logic [1:0] irq_gate;

  // Source enables decoded once from the registered control word
  // receive and stop source gates
  for (genvar g = 0; g < 2; g++) begin : g_src
    assign src_enable[g] = src_enable_of(r.ctrl, g);
  end

  // Next state of the whole core
  always_comb begin
    // Everything holds unless changed below
    n = r;
    ev_set = 2'h0;
    ack_now = 1'b0;
    wr_sel = addr_sel(paddr);
    wr_access = psel & penable & pwrite & r.pready;

    // APB answer prepared in setup, shown during access
    // pready pulses in the first access cycle: no wait states
    // Unmapped addresses answer with an error and read as zero
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = (wr_sel == i2c_slave_pkg::SEL_NONE);
      n.prdata = read_word(wr_sel, r, line.scl_level, line.sda_level);
    end

    // Register writes, taken in the completing access cycle
    // Reserved control bits are dropped on the way in
    // Status clears are handled below so that a new event wins
    if (wr_access) begin
      case (wr_sel)
        i2c_slave_pkg::SEL_CTRL: n.ctrl = pwdata[15:0] & `CTRL_IMPL_MASK;
        i2c_slave_pkg::SEL_MASK: n.irq_mask = pwdata[1:0];
        i2c_slave_pkg::SEL_OWNADDR: n.own_addr = pwdata[6:0];
        default: n.ctrl = n.ctrl;
      endcase
    end

    // Byte engine
    // A start, repeated or not, restarts address capture
    if (line.start_seen) begin
      // Any half-received byte is dropped
      n.state = i2c_slave_pkg::ST_ADDR;
      n.bit_cnt = 4'h0;
      n.ack_drive = 1'b0;
      n.addressed = 1'b0;
    end else if (line.stop_seen) begin
      // Counted whether or not this slave was addressed
      n.state = i2c_slave_pkg::ST_IDLE;
      n.ack_drive = 1'b0;
      n.addressed = 1'b0;
      ev_set[`IRQ_STOP] = 1'b1;
    end else begin
      case (r.state)
        i2c_slave_pkg::ST_IDLE: begin
          // Nothing driven until the next start
          n.ack_drive = 1'b0;
        end
        i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_DATA: begin
          // Bits taken on rising SCL, MSB first; decision on the next fall
          if (line.scl_rise && r.bit_cnt != `BITS_PER_BYTE) begin
            n.shift = {r.shift[6:0], line.sda_level};
            n.bit_cnt = r.bit_cnt + 4'h1;
          end else if (line.scl_fall && r.bit_cnt == `BITS_PER_BYTE) begin
            n.bit_cnt = 4'h0;
            if (r.state == i2c_slave_pkg::ST_ADDR) begin
              // Hardware acknowledges its own write address only
              n.addressed = (r.shift[7:1] == r.own_addr) && !r.shift[0];
              ack_now = n.addressed && !r.ctrl[`BIT_FORCE_NACK];
              n.state = i2c_slave_pkg::ST_ADDR_ACK;
            end else begin
              ack_now = !r.ctrl[`BIT_FORCE_NACK];
              // Received byte and its event, acked or not
              n.rx_data = r.shift;
              ev_set[`IRQ_RX] = 1'b1;
              n.state = i2c_slave_pkg::ST_DATA_ACK;
            end
            n.ack_drive = ack_now;
            n.last_ack = ack_now;
          end
        end
        i2c_slave_pkg::ST_ADDR_ACK: begin
          // An address other than the own write address waits in idle for the next start
          if (line.scl_fall) begin
            n.ack_drive = 1'b0;
            n.state = r.addressed ? i2c_slave_pkg::ST_DATA : i2c_slave_pkg::ST_IDLE;
          end
        end
        i2c_slave_pkg::ST_DATA_ACK: begin
          // A refused byte ends this slave's part of the transfer
          if (line.scl_fall) begin
            n.ack_drive = 1'b0;
            n.state = r.last_ack ? i2c_slave_pkg::ST_DATA : i2c_slave_pkg::ST_IDLE;
          end
        end
        default: begin
          // Unused codes fall back to idle
          n.state = i2c_slave_pkg::ST_IDLE;
          n.ack_drive = 1'b0;
        end
      endcase
    end

    // Clock stretching, acting on the control value just written
    // Rewriting the bit while it is set is not a new request
    // Only clearing the bit ends a hold; bus activity never does
    stretch_rise = n.ctrl[`BIT_STRETCH_ENABLE] & ~r.ctrl[`BIT_STRETCH_ENABLE];
    if (!n.ctrl[`BIT_STRETCH_ENABLE]) begin
      n.hold = 1'b0;
      n.hold_pending = 1'b0;
    end else if (stretch_rise && !line.scl_level) begin
      n.hold = 1'b1;
      n.hold_pending = 1'b0;
    end else if (stretch_rise) begin
      // SCL high at the write: wait for the master to pull it low
      n.hold_pending = 1'b1;
    end else if (r.hold_pending && line.scl_fall) begin
      n.hold = 1'b1;
      n.hold_pending = 1'b0;
    end

    // Disabled sources never record an event
    ev_set = ev_set & src_enable;

    // Sticky status: write one clears, a new event wins
    // The clear works on the old status, the event is ORed on top
    if (wr_access && wr_sel == i2c_slave_pkg::SEL_STATUS) begin
      n.irq_status = r.irq_status & ~pwdata[1:0];
    end
    n.irq_status = n.irq_status | ev_set;

    // Output follows the next status, mask and enables, so it moves
    // at the same edge as the status bit
    // only enabled, unmasked sources
    irq_gate[`IRQ_RX] = src_enable_of(n.ctrl, `IRQ_RX);
    irq_gate[`IRQ_STOP] = src_enable_of(n.ctrl, `IRQ_STOP);
    n.irq = |(n.irq_status & n.irq_mask & irq_gate);
  end

  // State register
  // Reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.ctrl <= `RST_SLAVE_CONTROL;
      r.irq_status <= `RST_IRQ_STATUS;
      r.irq_mask <= `RST_IRQ_MASK;
      r.own_addr <= `RST_OWN_ADDR;
      r.rx_data <= `RST_RX_DATA;
      r.shift <= 8'h00;
      r.bit_cnt <= 4'h0;
      r.state <= i2c_slave_pkg::ST_IDLE;
      r.addressed <= 1'b0;
      r.last_ack <= 1'b0;
      r.ack_drive <= 1'b0;
      r.hold <= 1'b0;
      r.hold_pending <= 1'b0;
      r.irq <= 1'b0;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= 32'h0000_0000;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from state; open-drain lines only pull low
  // The pin values stay low; the enables decide whether they reach the wire
  // Only the hold and the acknowledge ever pull a line
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign scl_oe = r.hold;
  assign scl_out = 1'b0;
  assign sda_oe = r.ack_drive;
  assign sda_out = 1'b0;
  assign irq = r.irq;

endmodule

// ===== verilog/i2c_slave_params.svh
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// Register byte offsets
`define OFS_SLAVE_CONTROL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_LINK_STATUS 8'h0c
`define OFS_RX_DATA 8'h10
`define OFS_OWN_ADDR 8'h14

// Slave control bit positions
`define BIT_RX_IRQ_ENABLE 9
`define BIT_STOP_IRQ_ENABLE 8
`define BIT_FORCE_NACK 7
`define BIT_STRETCH_ENABLE 6

// Only these control bits are held; the rest read as zero
`define CTRL_IMPL_MASK 16'h03c0

// Interrupt status and mask bit positions
`define IRQ_RX 0
`define IRQ_STOP 1

// Link status bit positions
`define LS_SCL 0
`define LS_SDA 1
`define LS_HOLD 2
`define LS_PENDING 3
`define LS_ADDRESSED 4
`define LS_LAST_ACK 5

// Reset values
`define RST_SLAVE_CONTROL 16'h0000
`define RST_IRQ_STATUS 2'h0
`define RST_IRQ_MASK 2'h0
`define RST_OWN_ADDR 7'h2a
`define RST_RX_DATA 8'h00

// Bits in one byte before the acknowledge slot
`define BITS_PER_BYTE 4'h8

`endif

// ===== verilog/i2c_slave_pkg.sv
package i2c_slave_pkg;

  // Byte engine states
  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_ADDR     = 5'b00010,
    ST_ADDR_ACK = 5'b00100,
    ST_DATA     = 5'b01000,
    ST_DATA_ACK = 5'b10000
  } xfer_state_t;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_STATUS,
    SEL_MASK,
    SEL_LINK,
    SEL_RXDATA,
    SEL_OWNADDR
  } reg_sel_t;

  // Pin front end state
  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
  } front_state_t;

  // Slave core state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [6:0] own_addr;
    logic [7:0] rx_data;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    xfer_state_t state;
    logic addressed;
    logic last_ack;
    logic ack_drive;
    logic hold;
    logic hold_pending;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_state_t;

endpackage

// ===== verilog/i2c_line_if.sv
`timescale 1ns/100ps
// Synchronised bus levels and events from the pin front end
interface i2c_line_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  modport front (
    output scl_level,
    output sda_level,
    output scl_rise,
    output scl_fall,
    output start_seen,
    output stop_seen
  );

  modport core (
    input scl_level,
    input sda_level,
    input scl_rise,
    input scl_fall,
    input start_seen,
    input stop_seen
  );
endinterface

// ===== verilog/i2c_line_front.sv
`timescale 1ns/100ps
module i2c_line_front (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Events to the core
  i2c_line_if.front line
);

  i2c_slave_pkg::front_state_t r;
  i2c_slave_pkg::front_state_t n;

  // Two-stage synchronisers, then one history stage
  always_comb begin
    n = r;
    n.scl_meta = scl_in;
    n.scl_sync = r.scl_meta;
    n.scl_prev = r.scl_sync;
    n.sda_meta = sda_in;
    n.sda_sync = r.sda_meta;
    n.sda_prev = r.sda_sync;
  end

  // Idle bus reads high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= 6'h3f;
    end else begin
      r <= n;
    end
  end

  // Edges and bus conditions from synchronised levels only
  assign line.scl_level = r.scl_sync;
  assign line.sda_level = r.sda_sync;
  assign line.scl_rise = r.scl_sync & ~r.scl_prev;
  assign line.scl_fall = ~r.scl_sync & r.scl_prev;
  assign line.start_seen = r.scl_sync & r.scl_prev & r.sda_prev & ~r.sda_sync;
  assign line.stop_seen = r.scl_sync & r.scl_prev & ~r.sda_prev & r.sda_sync;

endmodule

// ===== testbench/i2c_slave_ctrl_assertions.sv
`timescale 1ns/100ps
module i2c_slave_ctrl_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and interrupt
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic irq
);
  logic [15:0] ctrl_r;
  logic wr_ctrl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the committed control word
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == 8'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_r <= 16'h0000;
    else if (wr_ctrl) ctrl_r <= pwdata[15:0];
  end
  chk_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_map_error: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14}))
    else $error("error flag does not match address");
  chk_irq_source: assert property ($rose(irq) |-> ctrl_r[9] || ctrl_r[8])
    else $error("interrupt rose with sources off");
  chk_irq_quiet: assert property ((!ctrl_r[9] && !ctrl_r[8]) [*2] |-> !irq)
    else $error("interrupt high with sources off");
  chk_nack_force: assert property ($rose(sda_oe) |-> !ctrl_r[7] && !scl_in)
    else $error("acknowledge driven while forced off");
  chk_hold_now: assert property ((!scl_in) [*4] ##0 (wr_ctrl && pwdata[6]) |=> scl_oe)
    else $error("clock not held at once");
  chk_hold_low: assert property ($rose(scl_oe) |-> !$past(scl_in))
    else $error("hold began while clock high");
  chk_hold_keep: assert property ($fell(scl_oe) |-> !ctrl_r[6])
    else $error("hold dropped while enabled");
  chk_hold_release: assert property (wr_ctrl && !pwdata[6] |=> !scl_oe)
    else $error("hold kept after clearing");
endmodule

// ===== testbench/i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model (
  // Open-drain drive, low pulls the wire
  output logic scl_drv,
  output logic sda_drv,
  // Wire levels
  input wire logic scl_wire,
  input wire logic sda_wire
);
  // Idle bus, clock stands still high
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // One clock pulse, waiting out any stretch
  task pulse(output logic seen);
    #20 scl_drv = 1'b1;
    wait (scl_wire === 1'b1);
    #20 seen = sda_wire;
    #20 scl_drv = 1'b0;
    #20;
  endtask
  task start();
    #40 sda_drv = 1'b0;
    #40 scl_drv = 1'b0;
    #20;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_drv = b[i];
      pulse(s);
    end
    sda_drv = 1'b1;
    pulse(s);
    ack = !s;
  endtask
  task stop();
    sda_drv = 1'b0;
    #20 scl_drv = 1'b1;
    wait (scl_wire === 1'b1);
    #40 sda_drv = 1'b1;
    #40;
  endtask
endmodule

// ===== testbench/test_i2c_slave_ctrl.sv
`timescale 1ns/100ps
module test_i2c_slave_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, scl_drv, sda_drv, ack;
  logic [7:0] paddr, db;
  logic [31:0] pwdata, prdata, d;
  logic [33:0] note;
  logic [33:0] notes[$];
  int fails, comparisons;
  wire scl_wire = scl_drv & ~scl_oe;
  wire sda_wire = sda_drv & ~sda_oe;
  i2c_slave_ctrl u_i2c_slave_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_wire), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  i2c_master_model u_i2c_master_model (.scl_drv(scl_drv), .sda_drv(sda_drv),
    .scl_wire(scl_wire), .sda_wire(sda_wire));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude();
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One bus transfer; reads carry the expected data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic err);
    notes.push_back({w, err, v});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Completed transfers against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      compare("slave error", {31'h0, note[32]}, {31'h0, pslverr});
      if (!note[33]) compare("read data", note[31:0], prdata);
    end
  end
  task settle(input logic e);
    repeat (4) @(posedge pclk);
    compare("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task xfer(input logic [7:0] ab, input logic ea, input logic ed);
    u_i2c_master_model.start();
    u_i2c_master_model.put_byte(ab, ack);
    compare("address ack", {31'h0, ea}, {31'h0, ack});
    u_i2c_master_model.put_byte(db, ack);
    compare("data ack", {31'h0, ed}, {31'h0, ack});
    u_i2c_master_model.stop();
  endtask
  // Watchdog
  initial begin
    #100000;
    fails++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    d = $urandom(32'hacac);
    // Reset values, decode and kept bits
    apb(0, 8'h00, 32'h0, 0);
    apb(0, 8'h14, 32'h2a, 0);
    apb(1, 8'h18, 32'hffffffff, 1);
    apb(0, 8'h18, 32'h0, 1);
    d = $urandom;
    apb(1, 8'h00, d, 0);
    apb(0, 8'h00, d & 32'h3c0, 0);
    // Events recorded but masked, then stop unmasked and cleared
    apb(1, 8'h08, 32'h0, 0);
    apb(1, 8'h00, 32'h300, 0);
    db = 8'($urandom);
    xfer(8'h54, 1, 1);
    apb(0, 8'h10, {24'h0, db}, 0);
    apb(0, 8'h04, 32'h3, 0);
    settle(1'b0);
    apb(1, 8'h08, 32'h2, 0);
    settle(1'b1);
    apb(1, 8'h04, 32'h3, 0);
    settle(1'b0);
    // Receive source alone
    apb(1, 8'h08, 32'h3, 0);
    apb(1, 8'h00, 32'h200, 0);
    xfer(8'h54, 1, 1);
    settle(1'b1);
    apb(0, 8'h04, 32'h1, 0);
    apb(1, 8'h04, 32'h1, 0);
    // Sources off, foreign address, forced no-acknowledge
    apb(1, 8'h00, 32'h0, 0);
    xfer(8'h56, 0, 0);
    xfer(8'h54, 1, 1);
    settle(1'b0);
    apb(0, 8'h04, 32'h0, 0);
    apb(1, 8'h00, 32'h80, 0);
    xfer(8'h54, 0, 0);
    apb(1, 8'h00, 32'h0, 0);
    // Stretch set with the clock low
    u_i2c_master_model.start();
    u_i2c_master_model.put_byte(8'h54, ack);
    apb(1, 8'h00, 32'h40, 0);
    fork
      u_i2c_master_model.put_byte(db, ack);
      begin
        repeat (40) @(posedge pclk);
        compare("held clock", 32'h0, {31'h0, scl_wire});
        apb(0, 8'h0c, {26'h0, 4'hd, db[7], 1'b0}, 0);
        apb(1, 8'h00, 32'h0, 0);
      end
    join
    compare("late ack", 32'h1, {31'h0, ack});
    compare("pin levels", 32'h0, {30'h0, scl_out, sda_out});
    u_i2c_master_model.stop();
    // Stretch set with the clock high waits for a fall
    apb(1, 8'h00, 32'h40, 0);
    repeat (20) @(posedge pclk);
    compare("early hold", 32'h0, {31'h0, scl_oe});
    apb(0, 8'h0c, 32'h2b, 0);
    fork
      xfer(8'h54, 1, 1);
      begin
        for (int n = 0; n < 200 && scl_oe !== 1'b1; n++) @(posedge pclk);
        compare("late hold", 32'h1, {31'h0, scl_oe});
        repeat (40) @(posedge pclk);
        apb(1, 8'h00, 32'h0, 0);
      end
    join
    conclude();
  end
endmodule
bind i2c_slave_ctrl i2c_slave_ctrl_assertions u_i2c_slave_ctrl_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .irq(irq));
